// ===== cartridge_tape_host_port_bench.sv
`timescale 1ns/1ps
`include "tape_port_params.svh"
module cartridge_tape_host_port_bench;
    localparam int OS = 20;
    logic I_CLK = 1'b0;
    logic I_NRST = 1'b0;
    logic I_MODULE_IO_READ_STROBE_N = 1'b1;
    logic I_IO_WRITE_STROBE_N = 1'b1;
    logic I_ROM_ACCESS = 1'b0;
    logic [7:0] I_IO_ADDR = 8'h00;
    logic [7:0] I_IO_WDATA = 8'h00;
    logic I_LOCAL_DMA_GRANT_N = 1'b1;
    logic I_DMA_DONE = 1'b0;
    logic I_READY_N, I_ACK_N, I_DIRC_N;
    logic [7:0] I_TBUS, O_IO_RDATA, O_TBUS;
    logic O_HOST_TRANSCEIVER_ENABLE_N, O_ROM_SELECT_N, O_MEMORY_OPERATION_SELECT_N;
    logic O_BOOT_ENABLE, O_INTERRUPT, O_REQUEST_N, O_TRANSFER_N, O_TBUS_OE;
    logic O_BUFFERED_BUS_DIRECTION_N, O_LOCAL_DMA_REQUEST;
    logic [23:0] O_DMA_ADDR;
    logic [15:0] O_DMA_DATA;
    logic [7:0] base = 8'h00;
    logic [2:0] lag = 3'h0;
    logic end_cmd = 1'b0;
    logic [7:0] d;
    logic [22:0] a;
    logic en_n, rom_n, mem_n;
    int errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int seed = 91232;
    int n;
    tape_host_port #(.ONESHOT_CYCLES(OS)) u_dut (.I_CLK, .I_NRST, .I_MODULE_IO_READ_STROBE_N,
        .I_IO_WRITE_STROBE_N, .I_ROM_ACCESS, .I_IO_ADDR, .I_IO_WDATA, .O_IO_RDATA,
        .O_HOST_TRANSCEIVER_ENABLE_N, .O_ROM_SELECT_N, .O_MEMORY_OPERATION_SELECT_N,
        .O_BOOT_ENABLE, .O_INTERRUPT, .O_REQUEST_N, .O_TRANSFER_N, .I_READY_N, .I_ACK_N,
        .I_DIRC_N, .I_TBUS, .O_TBUS, .O_TBUS_OE, .O_BUFFERED_BUS_DIRECTION_N,
        .O_LOCAL_DMA_REQUEST, .I_LOCAL_DMA_GRANT_N, .I_DMA_DONE, .O_DMA_ADDR, .O_DMA_DATA);
    tape_drive_model u_drive (.i_clk(I_CLK), .i_request_n(O_REQUEST_N),
        .i_transfer_n(O_TRANSFER_N), .i_host_bus(O_TBUS), .i_host_oe(O_TBUS_OE),
        .i_base(base), .i_lag(lag), .i_nbytes(4'h4), .i_end_cmd(end_cmd),
        .o_ready_n(I_READY_N), .o_ack_n(I_ACK_N), .o_dirc_n(I_DIRC_N), .o_bus(I_TBUS));
    always #5 I_CLK = ~I_CLK;
    task automatic wrap_up();
        if (errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask
    task automatic await(ref logic sig, input logic val, input int lim, input string what);
        n = 0;
        while (sig !== val && n < lim) begin
            @(negedge I_CLK);
            n++;
        end
        chk(what, val, sig);
    endtask
    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        @(negedge I_CLK);
        I_IO_ADDR = adr;
        I_IO_WDATA = dat;
        I_IO_WRITE_STROBE_N = 1'b0;
        @(negedge I_CLK);
        I_IO_WRITE_STROBE_N = 1'b1;
    endtask
    task automatic rd(input logic [7:0] adr, input logic rom, output logic [7:0] dat);
        @(negedge I_CLK);
        I_IO_ADDR = adr;
        I_ROM_ACCESS = rom;
        I_MODULE_IO_READ_STROBE_N = 1'b0;
        @(negedge I_CLK);
        dat = O_IO_RDATA;
        {en_n, rom_n, mem_n} = {O_HOST_TRANSCEIVER_ENABLE_N, O_ROM_SELECT_N,
            O_MEMORY_OPERATION_SELECT_N};
        I_MODULE_IO_READ_STROBE_N = 1'b1;
        I_ROM_ACCESS = 1'b0;
    endtask
    task automatic end_pulse();
        end_cmd = 1'b1;
        repeat (3) @(negedge I_CLK);
        end_cmd = 1'b0;
        repeat (4) @(negedge I_CLK);
    endtask
    // generous ceiling: the full sequence needs well under two thousand cycles
    always @(posedge I_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (16) @(negedge I_CLK);
        I_NRST = 1'b1;
        repeat (3) @(negedge I_CLK);
        chk("idle lines", 4'b1100, {O_REQUEST_N, O_TRANSFER_N, O_INTERRUPT, O_LOCAL_DMA_REQUEST});
        repeat (4) begin
            d = 8'($random(seed));
            wr(`OFS_BOOT, d);
            repeat (2) @(negedge I_CLK);
            chk("boot enable", d[`BOOT_BIT], O_BOOT_ENABLE);
        end
        rd(8'h00, 1'b1, d);
        chk("rom selects", 3'b000, {en_n, rom_n, mem_n});
        rd(8'h86, 1'b0, d);
        chk("plain read", {8'h00, 3'b011}, {d, en_n, rom_n, mem_n});
        base = 8'($random(seed));
        lag = 3'($random(seed));
        wr(`OFS_CMD_STAT, `CMD_READ_STATUS);
        await(O_REQUEST_N, 1'b0, 10, "request on");
        chk("command on bus", {1'b1, `CMD_READ_STATUS}, {O_TBUS_OE, O_TBUS});
        await(O_REQUEST_N, 1'b1, 40, "request off");
        await(O_INTERRUPT, 1'b1, 60, "status irq");
        chk("bus inward", 0, O_BUFFERED_BUS_DIRECTION_N);
        rd(`OFS_CMD_STAT, 1'b1, d);
        repeat (2) @(negedge I_CLK);
        chk("rom read at status port", 2'b11, {O_INTERRUPT, O_REQUEST_N});
        rd(`OFS_LINE_STAT, 1'b0, d);
        chk("line status", 8'h05, d & 8'h05);
        rd(`OFS_CMD_STAT, 1'b0, d);
        chk("status byte", base, d);
        n = 0;
        repeat (OS + 10) begin
            @(negedge I_CLK);
            n += (O_REQUEST_N === 1'b0);
        end
        chk("one shot", 1, n >= OS && n <= OS + 1);
        chk("irq withdrawn", 0, O_INTERRUPT);
        repeat (5) begin
            rd(`OFS_CMD_STAT, 1'b0, d);
            chk("status byte", base, d);
        end
        await(O_REQUEST_N, 1'b1, OS + 5, "one shot end");
        end_pulse();
        chk("bus outward", 1, O_BUFFERED_BUS_DIRECTION_N);
        a = 23'($random(seed));
        wr(`OFS_ADDR_LO, a[7:0]);
        wr(`OFS_ADDR_MID, a[15:8]);
        wr(`OFS_ADDR_HI, {1'b0, a[22:16]});
        repeat (2) @(negedge I_CLK);
        chk("dma address", {a, 1'b0}, O_DMA_ADDR);
        base = 8'($random(seed));
        lag = 3'($random(seed));
        wr(`OFS_CMD_STAT, `CMD_READ_DATA);
        await(O_REQUEST_N, 1'b0, 10, "data request");
        await(O_INTERRUPT, 1'b1, 80, "data ready");
        for (int w = 0; w < 2; w++) begin
            await(O_LOCAL_DMA_REQUEST, 1'b1, 300, "dma request");
            chk("dma word", {base + 8'(2 * w + 1), base + 8'(2 * w)}, O_DMA_DATA);
            await(O_TRANSFER_N, 1'b1, 20, "transfer off");
            n = 0;
            repeat (30) begin
                @(negedge I_CLK);
                n += (O_TRANSFER_N === 1'b0);
            end
            chk("held transfer", 0, n);
            rd(`OFS_LINE_STAT, 1'b0, d);
            chk("word pending", 8'h0a, d & 8'h0a);
            @(negedge I_CLK);
            I_LOCAL_DMA_GRANT_N = 1'b0;
            repeat (2) @(negedge I_CLK);
            I_LOCAL_DMA_GRANT_N = 1'b1;
            @(negedge I_CLK);
            I_DMA_DONE = 1'b1;
            @(negedge I_CLK);
            I_DMA_DONE = 1'b0;
            @(negedge I_CLK);
            chk("dma cleared", 0, O_LOCAL_DMA_REQUEST);
            chk("next address", {a + 23'(w + 1), 1'b0}, O_DMA_ADDR);
            if (w == 0) await(O_TRANSFER_N, 1'b0, 10, "released transfer");
        end
        end_pulse();
        wrap_up();
    end
endmodule

// ===== drive_line_sync.sv
`timescale 1ns/1ps
module drive_line_sync (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ready_n,
    input wire logic i_ack_n,
    input wire logic i_dirc_n,
    input wire logic [7:0] i_tbus,
    drive_lines_if.src lines
);
    // stage 1 is read only by stage 2; edges look at stage 2 and its delayed copy
    logic [10:0] s1_q, s1_d, s2_q, s2_d;
    logic [1:0] prev_q, prev_d;

    always_comb begin
        s1_d = {i_tbus, ~i_dirc_n, ~i_ack_n, ~i_ready_n};
        s2_d = s1_q;
        prev_d = s2_q[1:0];
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_q <= 11'h000;
            s2_q <= 11'h000;
            prev_q <= 2'h0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            prev_q <= prev_d;
        end
    end

    assign lines.ready = s2_q[0];
    assign lines.ack = s2_q[1];
    assign lines.dirc = s2_q[2];
    assign lines.tbus = s2_q[10:3];
    assign lines.ready_fall = s2_q[0] & ~prev_q[0];
    assign lines.ack_fall = s2_q[1] & ~prev_q[1];
    assign lines.ack_rise = ~s2_q[1] & prev_q[1];

    ack_two_stage_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        lines.ack_fall |-> $past(~i_ack_n, 2))
        else $error("acknowledge used before two stages");
endmodule

// ===== drive_lines_if.sv
`timescale 1ns/1ps
interface drive_lines_if;
    logic ready;
    logic ready_fall;
    logic ack;
    logic ack_fall;
    logic ack_rise;
    logic dirc;
    logic [7:0] tbus;
    modport src (output ready, ready_fall, ack, ack_fall, ack_rise, dirc, tbus);
    modport dst (input ready, ready_fall, ack, ack_fall, ack_rise, dirc, tbus);
endinterface

// ===== tape_drive_model.sv
`timescale 1ns/1ps
module tape_drive_model (
    input wire logic i_clk,
    input wire logic i_request_n,
    input wire logic i_transfer_n,
    input wire logic [7:0] i_host_bus,
    input wire logic i_host_oe,
    input wire logic [7:0] i_base,
    input wire logic [2:0] i_lag,
    input wire logic [3:0] i_nbytes,
    input wire logic i_end_cmd,
    output logic o_ready_n,
    output logic o_ack_n,
    output logic o_dirc_n,
    output logic [7:0] o_bus
);
    logic [7:0] cmd_q;
    logic [7:0] drv;
    logic drv_oe;
    logic [7:0] last_q;
    int k;
    // a released bus shows the inverse of its last level, never a stale copy
    assign o_bus = i_host_oe ? i_host_bus : (drv_oe ? drv : ~last_q);
    always @(posedge i_clk) begin
        if (i_host_oe || drv_oe) begin
            last_q <= o_bus;
        end
    end
    task automatic lag();
        repeat (i_lag + 1) @(posedge i_clk);
        #1;
    endtask
    initial begin
        {o_ready_n, o_ack_n, o_dirc_n, drv_oe} = 4'b1110;
        drv = 8'h00;
        last_q = 8'h00;
        forever begin
            @(posedge i_clk);
            if (!i_request_n && i_host_oe) begin
                cmd_q = i_host_bus;
                lag();
                o_ready_n = 1'b0;
                while (!i_request_n) @(posedge i_clk);
                #1;
                o_ready_n = 1'b1;
                lag();
                o_dirc_n = 1'b0;
                drv_oe = 1'b1;
                drv = i_base;
                lag();
                o_ready_n = 1'b0;
                repeat (4) @(posedge i_clk);
                #1;
                o_ready_n = 1'b1;
                for (k = 0; cmd_q == 8'h40 && k < i_nbytes; k++) begin
                    drv = i_base + 8'(k);
                    lag();
                    o_ack_n = 1'b0;
                    while (i_transfer_n) @(posedge i_clk);
                    #1;
                    o_ack_n = 1'b1;
                    while (!i_transfer_n) @(posedge i_clk);
                    #1;
                end
                wait (i_end_cmd);
                o_dirc_n = 1'b1;
                drv_oe = 1'b0;
            end
        end
    end
endmodule

// ===== tape_host_port.sv
`timescale 1ns/1ps
`include "tape_port_params.svh"
module tape_host_port #(
    parameter int ONESHOT_CYCLES = `ONESHOT_CYC
) (
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic I_MODULE_IO_READ_STROBE_N,
    input wire logic I_IO_WRITE_STROBE_N,
    input wire logic I_ROM_ACCESS,
    input wire logic [7:0] I_IO_ADDR,
    input wire logic [7:0] I_IO_WDATA,
    output logic [7:0] O_IO_RDATA,
    output logic O_HOST_TRANSCEIVER_ENABLE_N,
    output logic O_ROM_SELECT_N,
    output logic O_MEMORY_OPERATION_SELECT_N,
    output logic O_BOOT_ENABLE,
    output logic O_INTERRUPT,
    output logic O_REQUEST_N,
    output logic O_TRANSFER_N,
    input wire logic I_READY_N,
    input wire logic I_ACK_N,
    input wire logic I_DIRC_N,
    input wire logic [7:0] I_TBUS,
    output logic [7:0] O_TBUS,
    output logic O_TBUS_OE,
    output logic O_BUFFERED_BUS_DIRECTION_N,
    output logic O_LOCAL_DMA_REQUEST,
    input wire logic I_LOCAL_DMA_GRANT_N,
    input wire logic I_DMA_DONE,
    output logic [23:0] O_DMA_ADDR,
    output logic [15:0] O_DMA_DATA
);
    drive_lines_if lines ();

    drive_line_sync u_sync (
        .i_clk(I_CLK),
        .i_nrst(I_NRST),
        .i_ready_n(I_READY_N),
        .i_ack_n(I_ACK_N),
        .i_dirc_n(I_DIRC_N),
        .i_tbus(I_TBUS),
        .lines(lines)
    );

    // cpu strobes share this clock; actions happen at the trailing edge
    logic rd_n_q, wr_n_q, grant_n_q, rom_q;
    logic [7:0] addr_q, wdata_q;
    logic wr_end, rd_end, cmd_wr, stat_rd, grant_end;

    always_comb begin
        wr_end = ~wr_n_q & I_IO_WRITE_STROBE_N;
        rd_end = ~rd_n_q & I_MODULE_IO_READ_STROBE_N;
        cmd_wr = wr_end & (addr_q == `OFS_CMD_STAT);
        // rom window is latched with the address: the live pin is gone at the trailing edge
        stat_rd = rd_end & (addr_q == `OFS_CMD_STAT) & ~rom_q;
        grant_end = ~grant_n_q & I_LOCAL_DMA_GRANT_N;
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            grant_n_q <= 1'b1;
            rom_q <= 1'b0;
            addr_q <= `RESET_BYTE;
            wdata_q <= `RESET_BYTE;
        end else begin
            rd_n_q <= I_MODULE_IO_READ_STROBE_N;
            wr_n_q <= I_IO_WRITE_STROBE_N;
            grant_n_q <= I_LOCAL_DMA_GRANT_N;
            if (!I_MODULE_IO_READ_STROBE_N || !I_IO_WRITE_STROBE_N) begin
                addr_q <= I_IO_ADDR;
                rom_q <= I_ROM_ACCESS;
                wdata_q <= I_IO_WDATA;
            end
        end
    end

    tape_port_pkg::ready_phase_e phase_q, phase_d;
    logic cmd_req_q, cmd_req_d, sec_ready_q, sec_ready_d;
    logic read_op_q, read_op_d, boot_q, boot_d;
    logic [7:0] cmd_byte_q, cmd_byte_d;
    logic [11:0] shot_q, shot_d;
    logic hi_q, hi_d, word_req_q, word_req_d;
    logic mem_wr_q, mem_wr_d, sync_mem_wr_q, sync_mem_wr_d;
    logic pend_q, pend_d, xfer_q, xfer_d;
    logic [7:0] lo_q, lo_d, hib_q, hib_d, rdata_d;
    tape_port_pkg::word_addr_t waddr_q, waddr_d;
    logic xcvr_n_d, rom_n_d, memory_operation_select_n_d, take;

    always_comb begin
        phase_d = phase_q;
        cmd_req_d = cmd_req_q;
        sec_ready_d = sec_ready_q;
        read_op_d = read_op_q;
        boot_d = boot_q;
        cmd_byte_d = cmd_byte_q;
        shot_d = (shot_q != 12'h000) ? shot_q - 12'h001 : 12'h000;
        hi_d = hi_q;
        word_req_d = word_req_q;
        mem_wr_d = mem_wr_q;
        sync_mem_wr_d = mem_wr_q & ~I_DMA_DONE;
        pend_d = pend_q;
        xfer_d = xfer_q;
        lo_d = lo_q;
        hib_d = hib_q;
        waddr_d = waddr_q;
        take = 1'b0;
        if (wr_end && addr_q == `OFS_BOOT) begin
            boot_d = wdata_q[`BOOT_BIT];
        end
        if (wr_end && addr_q == `OFS_ADDR_LO) begin
            waddr_d[7:0] = wdata_q;
        end
        if (wr_end && addr_q == `OFS_ADDR_MID) begin
            waddr_d[15:8] = wdata_q;
        end
        if (wr_end && addr_q == `OFS_ADDR_HI) begin
            waddr_d[22:16] = wdata_q[6:0];
        end
        if (grant_end) begin
            waddr_d = waddr_q + 23'h000001;
        end
        // ready sequencing: first ready drops the request, second says data is there
        unique case (phase_q)
            tape_port_pkg::PH_IDLE: begin
            end
            tape_port_pkg::PH_FIRST: begin
                if (lines.ready_fall) begin
                    cmd_req_d = 1'b0;
                    phase_d = tape_port_pkg::PH_SECOND;
                end
            end
            tape_port_pkg::PH_SECOND: begin
                if (lines.ready_fall) begin
                    phase_d = tape_port_pkg::PH_IDLE;
                end
            end
            default: phase_d = tape_port_pkg::PH_IDLE;
        endcase
        if (stat_rd) begin
            sec_ready_d = 1'b0;
            shot_d = ONESHOT_CYCLES[11:0];
        end
        if (phase_q == tape_port_pkg::PH_SECOND && lines.ready_fall) begin
            sec_ready_d = 1'b1;
        end
        if (cmd_wr) begin
            cmd_req_d = 1'b1;
            cmd_byte_d = wdata_q;
            phase_d = tape_port_pkg::PH_FIRST;
            read_op_d = (wdata_q == `CMD_READ_DATA);
            hi_d = 1'b0;
            pend_d = 1'b0;
        end
        // read byte path
        if (lines.ack_rise) begin
            xfer_d = 1'b0;
        end
        if (read_op_q && lines.ack_fall) begin
            if (mem_wr_q || word_req_q) begin
                pend_d = 1'b1;
            end else begin
                take = 1'b1;
            end
        end
        if (pend_q && !mem_wr_q && !word_req_q) begin
            take = 1'b1;
            pend_d = 1'b0;
        end
        // completion is applied first so that a new word raised in the same cycle wins
        if (I_DMA_DONE) begin
            mem_wr_d = 1'b0;
            word_req_d = 1'b0;
            sync_mem_wr_d = 1'b0;
        end
        if (take) begin
            xfer_d = 1'b1;
            hi_d = ~hi_q;
            if (!hi_q) begin
                lo_d = lines.tbus;
            end else begin
                hib_d = lines.tbus;
                word_req_d = 1'b1;
                mem_wr_d = 1'b1;
            end
        end
        xcvr_n_d = I_MODULE_IO_READ_STROBE_N & I_IO_WRITE_STROBE_N;
        rom_n_d = ~(~I_MODULE_IO_READ_STROBE_N & I_ROM_ACCESS);
        memory_operation_select_n_d = rom_n_d;
        rdata_d = `RESET_BYTE;
        if (!I_MODULE_IO_READ_STROBE_N && !I_ROM_ACCESS) begin
            if (I_IO_ADDR == `OFS_CMD_STAT) begin
                rdata_d = lines.tbus;
            end else if (I_IO_ADDR == `OFS_LINE_STAT) begin
                rdata_d[`LS_END_CMD] = sec_ready_q;
                rdata_d[`LS_READ_OP] = read_op_q;
                rdata_d[`LS_DIRC] = lines.dirc;
                rdata_d[`LS_WORD_REQ] = word_req_q;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            phase_q <= tape_port_pkg::PH_IDLE;
            cmd_req_q <= 1'b0;
            sec_ready_q <= 1'b0;
            read_op_q <= 1'b0;
            boot_q <= 1'b0;
            cmd_byte_q <= `RESET_BYTE;
            shot_q <= 12'h000;
            hi_q <= 1'b0;
            word_req_q <= 1'b0;
            mem_wr_q <= 1'b0;
            sync_mem_wr_q <= 1'b0;
            pend_q <= 1'b0;
            xfer_q <= 1'b0;
            lo_q <= `RESET_BYTE;
            hib_q <= `RESET_BYTE;
            waddr_q <= 23'h000000;
            O_IO_RDATA <= `RESET_BYTE;
            O_HOST_TRANSCEIVER_ENABLE_N <= 1'b1;
            O_ROM_SELECT_N <= 1'b1;
            O_MEMORY_OPERATION_SELECT_N <= 1'b1;
            O_REQUEST_N <= 1'b1;
            O_TRANSFER_N <= 1'b1;
            O_TBUS_OE <= 1'b0;
            O_BUFFERED_BUS_DIRECTION_N <= 1'b1;
        end else begin
            phase_q <= phase_d;
            cmd_req_q <= cmd_req_d;
            sec_ready_q <= sec_ready_d;
            read_op_q <= read_op_d;
            boot_q <= boot_d;
            cmd_byte_q <= cmd_byte_d;
            shot_q <= shot_d;
            hi_q <= hi_d;
            word_req_q <= word_req_d;
            mem_wr_q <= mem_wr_d;
            sync_mem_wr_q <= sync_mem_wr_d;
            pend_q <= pend_d;
            xfer_q <= xfer_d;
            lo_q <= lo_d;
            hib_q <= hib_d;
            waddr_q <= waddr_d;
            O_IO_RDATA <= rdata_d;
            O_HOST_TRANSCEIVER_ENABLE_N <= xcvr_n_d;
            O_ROM_SELECT_N <= rom_n_d;
            O_MEMORY_OPERATION_SELECT_N <= memory_operation_select_n_d;
            O_REQUEST_N <= ~(cmd_req_d | (shot_d != 12'h000));
            O_TRANSFER_N <= ~xfer_d;
            // command byte drives the tape bus only while the request stands
            O_TBUS_OE <= cmd_req_d & ~lines.dirc;
            O_BUFFERED_BUS_DIRECTION_N <= ~lines.dirc;
        end
    end

    // flops whose value is the output itself; the dma address adds a constant zero bit 0
    assign O_BOOT_ENABLE = boot_q;
    assign O_INTERRUPT = sec_ready_q;
    assign O_TBUS = cmd_byte_q;
    assign O_LOCAL_DMA_REQUEST = sync_mem_wr_q;
    assign O_DMA_ADDR = {waddr_q, 1'b0};
    assign O_DMA_DATA = {hib_q, lo_q};

    req_on_cmd_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        cmd_wr |=> !O_REQUEST_N && cmd_req_q)
        else $error("command write did not raise request");
    req_drop_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        (phase_q == tape_port_pkg::PH_FIRST && lines.ready_fall && !cmd_wr) |=> !cmd_req_q)
        else $error("first ready did not clear request");
    second_irq_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        (phase_q == tape_port_pkg::PH_SECOND && lines.ready_fall) |=> O_INTERRUPT)
        else $error("second ready gave no interrupt");
    stat_clear_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        (stat_rd && !(phase_q == tape_port_pkg::PH_SECOND && lines.ready_fall)) |=> !O_INTERRUPT)
        else $error("status read left interrupt standing");
    oneshot_hold_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        stat_rd |=> (shot_q == ONESHOT_CYCLES[11:0]) ##1 !O_REQUEST_N [*8])
        else $error("one-shot did not hold request");
    rom_sel_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        (!I_MODULE_IO_READ_STROBE_N && I_ROM_ACCESS) |=>
        !O_ROM_SELECT_N && !O_MEMORY_OPERATION_SELECT_N && !O_HOST_TRANSCEIVER_ENABLE_N)
        else $error("rom read not enabled");
    dirc_turn_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        lines.dirc |=> !O_BUFFERED_BUS_DIRECTION_N && !O_TBUS_OE)
        else $error("transceiver not turned inward");
    xfer_withheld_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        $fell(O_TRANSFER_N) |-> !$past(word_req_q))
        else $error("transfer given during pending dma");
    dma_req_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        ($rose(mem_wr_q) && !I_DMA_DONE) |=> O_LOCAL_DMA_REQUEST)
        else $error("word did not raise dma request");
    done_clear_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        (I_DMA_DONE && !take) |=> !mem_wr_q && !O_LOCAL_DMA_REQUEST)
        else $error("dma completion left write flags");
    addr_load_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        (wr_end && addr_q == `OFS_ADDR_LO && !grant_end) |=> waddr_q[7:0] == $past(wdata_q))
        else $error("address low byte not loaded");

    status_cycle_c: cover property (@(posedge I_CLK) disable iff (!I_NRST)
        O_INTERRUPT ##[1:1000] stat_rd);
    word_done_c: cover property (@(posedge I_CLK) disable iff (!I_NRST)
        $rose(O_LOCAL_DMA_REQUEST) ##[1:1000] I_DMA_DONE);
    third_byte_c: cover property (@(posedge I_CLK) disable iff (!I_NRST)
        pend_q ##[1:1000] $fell(O_TRANSFER_N));
endmodule

// ===== tape_port_params.svh
// Functional notes
// - rom read drives transceiver enable, rom select and memory-operation during cycle.
// - trailing edge of a command write sets the request flag, asserting REQUEST-.
// - first READY- after a request clears the request flag, releasing REQUEST-.
// - while DIRC- is asserted the tape bus transceiver points inward.
// - second READY- of a status command sets second-ready and the interrupt.
// - a status read clears second-ready, which withdraws the interrupt.
// - each status read holds REQUEST- asserted for 20 microseconds.
// - 23-bit dma word address loaded bytewise at 8ah, 8ch, 8eh; bit 0 zero.
// - in a read data command the second READY- sets second-ready.
// - drive gives ACK- with each byte, block answers TRANSFER-, drive drops ACK-.
// - drive acknowledge passes two flip-flops before use.
// - first byte to low register, second to high, then request dma write.
// - no TRANSFER- while a dma write request is pending.
// - a byte acknowledged during dma is recorded and answered after the write clears.
// - dma completion clears the memory write flags, releasing held transfers.
// - REQUEST- from a command write tells the drive a command byte stands on the tape bus; the status-read one-shot drives none.
`ifndef TAPE_PORT_PARAMS_SVH
`define TAPE_PORT_PARAMS_SVH
`define OFS_BOOT 8'h0a
`define OFS_CMD_STAT 8'h80
`define OFS_LINE_STAT 8'h84
`define OFS_ADDR_LO 8'h8a
`define OFS_ADDR_MID 8'h8c
`define OFS_ADDR_HI 8'h8e
`define BOOT_BIT 2
`define CMD_READ_STATUS 8'hc0
`define CMD_READ_DATA 8'h40
`define LS_END_CMD 0
`define LS_READ_OP 1
`define LS_DIRC 2
`define LS_WORD_REQ 3
`define CLK_PERIOD_NS 10
`define ONESHOT_NS 20000
`define ONESHOT_CYC ((`ONESHOT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_BYTE 8'h00
`endif

// ===== tape_port_pkg.sv
package tape_port_pkg;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_FIRST = 2'b01,
        PH_SECOND = 2'b11
    } ready_phase_e;
    typedef logic [22:0] word_addr_t;
endpackage
